// ---- pdio_consts.svh ----
// Constant definitions for the parallel digital I/O block.
`ifndef PDIO_CONSTS_SVH
`define PDIO_CONSTS_SVH
`define PDIO_LINES 24
`define PDIO_BYTE_W 8
`define PDIO_NIB_W 4
`define PDIO_NUM_OPREGS 16
`define PDIO_NUM_FNREGS 8
`define PDIO_OPREG_SPAN 64
`define PDIO_LATCH_RST 8'h00
`define PDIO_DIR_RST 1'b0
`define PDIO_PORT_FIRST 2'h0
`define PDIO_PORT_SECOND 2'h1
`define PDIO_PORT_SPLIT 2'h2
`define PDIO_PORT_CTRL 2'h3
`define PDIO_CTRL_DIR_FIRST 0
`define PDIO_CTRL_DIR_SECOND 1
`define PDIO_CTRL_DIR_LOW 2
`define PDIO_CTRL_DIR_HIGH 3
`define PDIO_CTRL_IRQ_CLR 4
`define PDIO_MODE_BASIC 1'b0
`endif

// ---- pdio_pkg.sv ----
// Types shared by the parallel digital I/O block.
package pdio_pkg;
    typedef enum logic [1:0] {
        PDIO_SEL_FIRST,
        PDIO_SEL_SECOND,
        PDIO_SEL_SPLIT,
        PDIO_SEL_CTRL
    } pdio_sel_t;

    typedef struct packed {
        logic dirHigh;
        logic dirLow;
        logic dirSecond;
        logic dirFirst;
    } pdio_dir_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [1:0] addr;
        logic [7:0] wrData;
    } pdio_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] outEn;
    } pdio_pin_t;

    typedef enum logic {
        PDIO_IRQ_IDLE,
        PDIO_IRQ_PENDING
    } pdio_irq_state_t;
endpackage : pdio_pkg

// ---- pdio_port_slice.sv ----
// One byte-wide port slice with latch, direction per group and pin drive.
`timescale 1ns/1ps
`include "pdio_consts.svh"
module pdio_port_slice #(
    parameter int GROUP_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic [(8/GROUP_W)-1:0] dirOut,
    input wire logic [7:0] pinIn,
    output logic [7:0] rdData,
    output pdio_pkg::pdio_pin_t pinOut
);
    import pdio_pkg::*;

    // Elaboration check: only whole-byte or nibble direction groups are served.
    generate
        if (GROUP_W != 8 && GROUP_W != 4) begin : g_bad_width
            $error("GROUP_W must be 8 or 4");
        end
    endgenerate

    logic [7:0] latch_ff;
    logic [7:0] nxt_latch;
    logic [7:0] groupMask;

    // Direction bits fan out to each line of their group.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
            assign groupMask[gi] = dirOut[gi / GROUP_W];
        end
    endgenerate

    // Writes load the latch whatever the direction; pins stay untouched for inputs.
    assign nxt_latch = wrEn ? wrData : latch_ff;
    // Output lines read back the latch, input lines read the pins.
    assign rdData = (latch_ff & groupMask) | (pinIn & ~groupMask);

    // Output latch, cleared by reset.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latch_ff <= `PDIO_LATCH_RST;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    assign pinOut.data = latch_ff;
    assign pinOut.outEn = groupMask;
endmodule : pdio_port_slice

// ---- pdio_irq_detect.sv ----
// Edge detector for the external interrupt request with enable gating.
`timescale 1ns/1ps
`include "pdio_consts.svh"
module pdio_irq_detect (
    input wire logic clock,
    input wire logic rstn,
    input wire logic irqEnableN,
    input wire logic irqRequest,
    input wire logic clearPulse,
    output logic irqPending
);
    import pdio_pkg::*;

    logic reqPrev_ff;
    pdio_irq_state_t state_ff;
    pdio_irq_state_t nxt_state;
    logic riseSeen;

    // Rising edge only, honoured while the enable input is low.
    assign riseSeen = irqRequest & ~reqPrev_ff & ~irqEnableN;

    // Pending flag: a new edge wins over a clear in the same cycle.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PDIO_IRQ_IDLE: begin
                if (riseSeen) nxt_state = PDIO_IRQ_PENDING;
            end
            PDIO_IRQ_PENDING: begin
                if (clearPulse && !riseSeen) nxt_state = PDIO_IRQ_IDLE;
            end
            default: nxt_state = PDIO_IRQ_IDLE;
        endcase
    end

    // Request history and state registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reqPrev_ff <= 1'b0;
            state_ff <= PDIO_IRQ_IDLE;
        end else begin
            reqPrev_ff <= irqRequest;
            state_ff <= nxt_state;
        end
    end

    assign irqPending = (state_ff == PDIO_IRQ_PENDING);
endmodule : pdio_irq_detect

// ---- pdio_top.sv ----
// Top of the 24-line parallel digital I/O block behind a target-only port.
`timescale 1ns/1ps
`include "pdio_consts.svh"
module pdio_top (
    input wire logic clock,
    input wire logic rstn,
    input wire pdio_pkg::pdio_req_t hostReq,
    output logic [7:0] hostRdData,
    output logic hostRdValid,
    input wire logic [23:0] lineIn,
    output logic [23:0] lineOut,
    output logic [23:0] lineOutEn,
    input wire logic irqEnableN,
    input wire logic irqRequest,
    output logic irqPending,
    output logic busMasterReq
);
    import pdio_pkg::*;

    // Elaboration check: the operation registers must fill their byte span exactly.
    generate
        if (`PDIO_NUM_OPREGS * 4 != `PDIO_OPREG_SPAN) begin : g_bad_span
            $error("operation register span mismatch");
        end
    endgenerate

    // ************************************************************
    // Register access decode
    // ************************************************************
    pdio_dir_t dir_ff;
    pdio_dir_t nxt_dir;
    logic [7:0] rdData_ff;
    logic rdValid_ff;
    logic wrFirst;
    logic wrSecond;
    logic wrSplit;
    logic wrCtrl;
    logic irqClear;
    logic [7:0] rdFirst;
    logic [7:0] rdSecond;
    logic [7:0] rdSplit;
    logic [7:0] ctrlView;
    logic [7:0] nxt_rdData;
    pdio_pin_t pinFirst;
    pdio_pin_t pinSecond;
    pdio_pin_t pinSplit;

    // Simple pass-through target decode over four byte slots.
    assign wrFirst = hostReq.wrEn && (hostReq.addr == `PDIO_PORT_FIRST);
    assign wrSecond = hostReq.wrEn && (hostReq.addr == `PDIO_PORT_SECOND);
    assign wrSplit = hostReq.wrEn && (hostReq.addr == `PDIO_PORT_SPLIT);
    assign wrCtrl = hostReq.wrEn && (hostReq.addr == `PDIO_PORT_CTRL);
    assign irqClear = wrCtrl && hostReq.wrData[`PDIO_CTRL_IRQ_CLR];

    // Direction bits are loaded from a control write; one bit per group.
    assign nxt_dir = wrCtrl ? pdio_dir_t'(hostReq.wrData[3:0]) : dir_ff;

    // Control view shows directions and the pending flag.
    assign ctrlView = {3'h0, irqPending, dir_ff.dirHigh, dir_ff.dirLow, dir_ff.dirSecond, dir_ff.dirFirst};

    // Read data selection by address.
    assign nxt_rdData = (hostReq.addr == `PDIO_PORT_FIRST) ? rdFirst :
                        (hostReq.addr == `PDIO_PORT_SECOND) ? rdSecond :
                        (hostReq.addr == `PDIO_PORT_SPLIT) ? rdSplit : ctrlView;

    // Direction register and read return, reset to all inputs.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dir_ff <= pdio_dir_t'({4{`PDIO_DIR_RST}});
            rdData_ff <= 8'h00;
            rdValid_ff <= 1'b0;
        end else begin
            dir_ff <= nxt_dir;
            rdData_ff <= hostReq.rdEn ? nxt_rdData : rdData_ff;
            rdValid_ff <= hostReq.rdEn;
        end
    end

    assign hostRdData = rdData_ff;
    assign hostRdValid = rdValid_ff;
    assign busMasterReq = 1'b0;

    // ************************************************************
    // Port slices
    // ************************************************************
    // Basic latched mode only: every slice is a plain latch with direction.
    pdio_port_slice #(.GROUP_W(8)) u_first (
        .clock(clock),
        .rstn(rstn),
        .wrEn(wrFirst),
        .wrData(hostReq.wrData),
        .dirOut(dir_ff.dirFirst),
        .pinIn(lineIn[7:0]),
        .rdData(rdFirst),
        .pinOut(pinFirst)
    );

    pdio_port_slice #(.GROUP_W(8)) u_second (
        .clock(clock),
        .rstn(rstn),
        .wrEn(wrSecond),
        .wrData(hostReq.wrData),
        .dirOut(dir_ff.dirSecond),
        .pinIn(lineIn[15:8]),
        .rdData(rdSecond),
        .pinOut(pinSecond)
    );

    pdio_port_slice #(.GROUP_W(4)) u_split (
        .clock(clock),
        .rstn(rstn),
        .wrEn(wrSplit),
        .wrData(hostReq.wrData),
        .dirOut({dir_ff.dirHigh, dir_ff.dirLow}),
        .pinIn(lineIn[23:16]),
        .rdData(rdSplit),
        .pinOut(pinSplit)
    );

    // Pin drive assembly.
    assign lineOut = {pinSplit.data, pinSecond.data, pinFirst.data};
    assign lineOutEn = {pinSplit.outEn, pinSecond.outEn, pinFirst.outEn};

    // ************************************************************
    // External interrupt
    // ************************************************************
    pdio_irq_detect u_irq (
        .clock(clock),
        .rstn(rstn),
        .irqEnableN(irqEnableN),
        .irqRequest(irqRequest),
        .clearPulse(irqClear),
        .irqPending(irqPending)
    );
endmodule : pdio_top

// ---- pdio_ext_model.sv ----
// Model of the equipment wired to the 24 lines and the interrupt pins.
`timescale 1ns/1ps
module pdio_ext_model (
    input wire logic [23:0] lineOut,
    input wire logic [23:0] lineOutEn,
    input wire logic [23:0] extDrive,
    input wire logic pulse,
    output logic [23:0] lineIn,
    output logic irqRequest
);
    // A line shows the block's drive where enabled, else the equipment's level.
    assign lineIn = (lineOut & lineOutEn) | (extDrive & ~lineOutEn);
    // The equipment signals a request by a rising edge only.
    assign irqRequest = pulse;
endmodule : pdio_ext_model

// ---- pdio_sva.sv ----
// Assertion checker for the parallel digital I/O top.
`timescale 1ns/1ps
module pdio_sva (
    input wire logic clock,
    input wire logic rstn,
    input wire pdio_pkg::pdio_req_t hostReq,
    input wire logic [7:0] hostRdData,
    input wire logic hostRdValid,
    input wire logic [23:0] lineIn,
    input wire logic [23:0] lineOut,
    input wire logic [23:0] lineOutEn,
    input wire logic irqEnableN,
    input wire logic irqRequest,
    input wire logic irqPending,
    input wire logic busMasterReq
);
    import pdio_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // A write to the control slot.
    sequence s_ctrl_wr;
        hostReq.wrEn && hostReq.addr == 2'h3;
    endsequence
    a_dir_split:
    assert property (s_ctrl_wr |=> lineOutEn[23:16] == {{4{$past(hostReq.wrData[3])}}, {4{$past(hostReq.wrData[2])}}})
        else $error("split directions wrong");
    a_dir_bytes:
    assert property (s_ctrl_wr |=> lineOutEn[15:0] == {{8{$past(hostReq.wrData[1])}}, {8{$past(hostReq.wrData[0])}}})
        else $error("byte directions wrong");
    a_first_latch:
    assert property (hostReq.wrEn && hostReq.addr == 2'h0 |=> lineOut[7:0] == $past(hostReq.wrData))
        else $error("first latch not loaded");
    a_read_answer:
    assert property (hostReq.rdEn |=> hostRdValid) else $error("read not answered");
    a_out_readback:
    assert property (hostReq.rdEn && !hostReq.wrEn && hostReq.addr == 2'h1 && lineOutEn[8]
        |=> hostRdData == $past(lineOut[15:8])) else $error("output read not latch");
    a_read_quiet:
    assert property (hostReq.rdEn && !hostReq.wrEn |=> $stable(lineOut) && $stable(lineOutEn))
        else $error("read disturbed lines");
    a_no_master:
    assert property (!busMasterReq) else $error("master request raised");
    a_irq_set:
    assert property ($rose(irqRequest) && !irqEnableN |=> irqPending) else $error("edge missed");
    a_irq_masked:
    assert property (!irqPending && irqEnableN |=> !irqPending) else $error("masked edge taken");
    a_irq_hold:
    assert property (irqPending && !(hostReq.wrEn && hostReq.addr == 2'h3 && hostReq.wrData[4])
        |=> irqPending) else $error("pending lost");
endmodule : pdio_sva
bind pdio_top pdio_sva pdio_sva_inst (.clock, .rstn, .hostReq, .hostRdData, .hostRdValid, .lineIn,
    .lineOut, .lineOutEn, .irqEnableN, .irqRequest, .irqPending, .busMasterReq);

// ---- pdio_tb.sv ----
// Self-checking testbench for the parallel digital I/O block.
`timescale 1ns/1ps
module tb;
    import pdio_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    pdio_req_t hostReq = '0;
    logic [7:0] hostRdData;
    logic hostRdValid, irqPending, busMasterReq, irqRequest;
    logic [23:0] lineIn, lineOut, lineOutEn;
    logic [23:0] ext = 24'h0, latch = 24'h0;
    logic [3:0] dir = 4'h0;
    logic irqEnableN = 1'b1, pulse = 1'b0, pendExp = 1'b0;
    logic [7:0] expQ[$];
    integer seed = 32'h555e993f;
    int fail_count = 0, checks = 0;
    pdio_top pdio_top_inst (.clock, .rstn, .hostReq, .hostRdData, .hostRdValid, .lineIn, .lineOut,
        .lineOutEn, .irqEnableN, .irqRequest, .irqPending, .busMasterReq);
    pdio_ext_model pdio_ext_model_inst (.lineOut, .lineOutEn, .extDrive(ext), .pulse, .lineIn, .irqRequest);
    // Free-running clock.
    always #10 clock = ~clock;
    // Counts a comparison and reports a mismatch.
    task check(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Drive enables of the three ports for a direction nibble.
    function automatic logic [23:0] oe(input logic [3:0] d);
        return {{4{d[3]}}, {4{d[2]}}, {8{d[1]}}, {8{d[0]}}};
    endfunction : oe
    // Presents one request for a cycle with fresh pin levels; reads note their byte.
    task op(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        logic [23:0] v;
        @(negedge clock);
        ext = $random(seed);
        v = (latch & oe(dir)) | (ext & ~oe(dir));
        hostReq <= '{wrEn: w, rdEn: r, addr: a, wrData: d};
        if (r && a == 2'h3) expQ.push_back({3'h0, pendExp, dir});
        else if (r) expQ.push_back(v[8*a +: 8]);
        if (w && a == 2'h3) dir = d[3:0];
        else if (w) latch[8*a +: 8] = d;
    endtask : op
    // Prints the counts and the verdict, then stops.
    task end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // Takes the oldest expected byte whenever read data is flagged.
    always @(negedge clock) begin
        if (hostRdValid === 1'b1) begin
            if (expQ.size() == 0) check(24'h1, 24'h0);
            else check({16'h0, hostRdData}, {16'h0, expQ.pop_front()});
        end
    end
    // Cuts a hang short.
    initial begin
        #20us;
        fail_count++;
        end_of_test();
    end
    // Main sequence of tests.
    initial begin
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        check(lineOutEn, 24'h0);
        check(lineOut, 24'h0);
        for (int i = 0; i < 3; i++) begin
            op(1'b0, 1'b1, i[1:0], 8'h00);
            op(1'b1, 1'b0, i[1:0], 8'($random(seed)));
            op(1'b0, 1'b1, i[1:0], 8'h00);
        end
        op(1'b0, 1'b0, 2'h0, 8'h00);
        check(lineOutEn, 24'h0);
        $display("test input ports done");
        for (int k = 0; k < 16; k++) begin
            op(1'b1, 1'b0, 2'h3, {4'h0, k[3:0]});
            op(1'b0, 1'b0, 2'h0, 8'h00);
            check(lineOutEn, oe(dir));
            for (int i = 0; i < 3; i++) begin
                op(1'b1, 1'b0, i[1:0], 8'($random(seed)));
                op(1'b0, 1'b1, i[1:0], 8'h00);
            end
            op(1'b0, 1'b0, 2'h0, 8'h00);
            check(lineOut, latch);
        end
        $display("test directions done");
        pulse = 1'b1;
        repeat (2) op(1'b0, 1'b0, 2'h0, 8'h00);
        check({23'h0, irqPending}, 24'h0);
        pulse = 1'b0;
        irqEnableN = 1'b0;
        op(1'b0, 1'b0, 2'h0, 8'h00);
        pulse = 1'b1;
        repeat (2) op(1'b0, 1'b0, 2'h0, 8'h00);
        pulse = 1'b0;
        repeat (3) op(1'b0, 1'b0, 2'h0, 8'h00);
        check({23'h0, irqPending}, 24'h1);
        pendExp = 1'b1;
        op(1'b0, 1'b1, 2'h3, 8'h00);
        op(1'b1, 1'b0, 2'h3, {4'h1, dir});
        pendExp = 1'b0;
        op(1'b0, 1'b0, 2'h0, 8'h00);
        check({23'h0, irqPending}, 24'h0);
        op(1'b0, 1'b1, 2'h3, 8'h00);
        op(1'b0, 1'b0, 2'h0, 8'h00);
        $display("test interrupt done");
        rstn = 1'b0;
        op(1'b0, 1'b0, 2'h0, 8'h00);
        check(lineOut, 24'h0);
        check(lineOutEn, 24'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule : tb
